// ### rtl/asc_map.vh
// Purpose: constants for the acquisition sample clock select block
// Assumes: 10 MHz core clock, classic Wishbone register access
// Notes:   included by bare name, definitions only
//
// Contract
// - three clock modes: internal, external, custom
// - internal periods step in 1-2-5 sequence
// - general mode periods 10 ns to 1 ms, default 10 ns
// - fast mode periods 2.5 ns to 1 ms, default 5 ns
// - channels 96 general, 48 fast, 24 at 2.5 ns
// - narrower width deepens memory: 8K, 16K, 32K
// - clock modes allowed depend on support mode
// - at most four equation lines; fifth add refused
// - equation lines are ORed into the strobe
// - one clock term ANDed with zero to three qualifiers
// - rising or falling edge chosen per line
// - each qualifier active high or active low
// - two leftmost qualifiers combined, then third, AND/OR
// - qualifier result ANDed with the clock edge
// - four edge sensitive clock lines 0 to 3
// - four level gate lines with internal complements
// - clock lines usable as level qualifiers, true/inverted
// - clock n excludes clock n and gate n as qualifiers
// - default is one line, rising edge of clock 3
`ifndef ASC_MAP_VH
`define ASC_MAP_VH

// register byte offsets
`define ASC_OFF_CTRL      8'h00
`define ASC_OFF_STATUS    8'h04
`define ASC_OFF_LINE_CMD  8'h08
`define ASC_OFF_SMP_CNT   8'h0C
`define ASC_OFF_LINE0     8'h10
`define ASC_OFF_LINE3     8'h1C

// control fields
`define ASC_CTRL_SUP      1:0
`define ASC_CTRL_CLK      5:4
`define ASC_CTRL_PER      12:8
`define ASC_SUP_GP        2'h0
`define ASC_SUP_FAST      2'h1
`define ASC_SUP_CUSTOM    2'h2
`define ASC_CLK_INT       2'h0
`define ASC_CLK_EXT       2'h1
`define ASC_CLK_CUSTOM    2'h2

// status fields
`define ASC_ST_WIDTH      6:0
`define ASC_ST_DEPTH      13:8
`define ASC_ST_LINES      18:16
`define ASC_ST_REFUSED    24

// line command fields
`define ASC_CMD_IDX       1:0
`define ASC_CMD_ADD       4
`define ASC_CMD_DEL       5
`define ASC_CMD_DEF       6

// equation line fields
`define ASC_LN_SEL        1:0
`define ASC_LN_FALL       2
`define ASC_LN_Q0         7:3
`define ASC_LN_Q1         12:8
`define ASC_LN_Q2         17:13
`define ASC_LN_OP1        18
`define ASC_LN_OP2        19
`define ASC_Q_EN          4
`define ASC_Q_INV         3
`define ASC_Q_CLK         2
`define ASC_Q_IDX         1:0
`define ASC_LN_DEFAULT    20'h00003
`define ASC_LINES_MAX     3'h4
`define ASC_LINES_ONE     3'h1

// time base period indices
`define ASC_PER_IDX_2P5NS 5'h00
`define ASC_PER_IDX_5NS   5'h01
`define ASC_PER_IDX_10NS  5'h02
`define ASC_PER_IDX_MAX   5'h11

// periods in picoseconds, 1-2-5 steps
`define ASC_CLK_PS        100000
`define ASC_PER_2P5NS_PS  2500
`define ASC_PER_5NS_PS    5000
`define ASC_PER_10NS_PS   10000
`define ASC_PER_20NS_PS   20000
`define ASC_PER_50NS_PS   50000
`define ASC_PER_100NS_PS  100000
`define ASC_PER_200NS_PS  200000
`define ASC_PER_500NS_PS  500000
`define ASC_PER_1US_PS    1000000
`define ASC_PER_2US_PS    2000000
`define ASC_PER_5US_PS    5000000
`define ASC_PER_10US_PS   10000000
`define ASC_PER_20US_PS   20000000
`define ASC_PER_50US_PS   50000000
`define ASC_PER_100US_PS  100000000
`define ASC_PER_200US_PS  200000000
`define ASC_PER_500US_PS  500000000
`define ASC_PER_1MS_PS    1000000000

// channel widths and memory depth in K samples
`define ASC_WIDTH_FULL    7'h60
`define ASC_WIDTH_HALF    7'h30
`define ASC_WIDTH_QUARTER 7'h18
`define ASC_DEPTH_FULL_K  6'h08
`define ASC_DEPTH_HALF_K  6'h10
`define ASC_DEPTH_QUART_K 6'h20

`endif

// ### rtl/asc_sample_clock_select.v
// Purpose: sample clock generation for an acquisition card
// Assumes: target lines are asynchronous and slow against core_clk_i
// Notes:   registers over classic Wishbone, one strobe pulse per sample
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "asc_map.vh"

module asc_sample_clock_select #(
  parameter [13:0] PER_500US_CYCLES = 14'd5000,
  parameter [13:0] PER_1MS_CYCLES   = 14'd10000
) (
  input  wire        core_clk_i,
  input  wire        rst_n_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        target_clk_line_0_i,
  input  wire        target_clk_line_1_i,
  input  wire        target_clk_line_2_i,
  input  wire        target_clk_line_3_i,
  input  wire        level_gate_line_0_i,
  input  wire        level_gate_line_1_i,
  input  wire        level_gate_line_2_i,
  input  wire        level_gate_line_3_i,
  input  wire        custom_strobe_i,
  output reg         sample_strobe_o,
  output reg         custom_sel_o,
  output reg  [6:0]  chan_width_o,
  output reg  [5:0]  mem_depth_k_o
);

  // control state
  reg  [1:0]  sup_mode;
  reg  [1:0]  clk_mode;
  reg  [4:0]  per_idx;
  reg  [2:0]  line_cnt;
  reg  [19:0] line_cfg [0:3];
  reg         refused;
  reg  [31:0] smp_cnt;
  reg  [13:0] tb_cnt;
  reg         tb_tick;

  // target line synchronisers
  reg  [7:0]  sync1;
  reg  [7:0]  sync2;
  reg  [7:0]  sync3;
  wire [7:0]  raw_lines;
  wire [3:0]  clk_lvl;
  wire [3:0]  gate_lvl;
  wire [3:0]  clk_rise;
  wire [3:0]  clk_fall;

  // bus decode
  wire        bus_req;
  wire        wr_stb;
  wire [31:0] wmask;
  wire        hit_line;
  wire [1:0]  line_adr;
  wire [31:0] ctrl_rd;
  wire [31:0] ctrl_new;
  wire [19:0] line_new;
  wire [1:0]  new_sup;
  wire [1:0]  new_clk;
  wire [4:0]  new_per;

  reg         next_strobe;
  reg  [3:0]  line_hits;
  reg         ctrl_ok;
  reg  [13:0] tb_target;
  reg  [31:0] rd_data;
  integer     i;
  integer     j;

  assign raw_lines = {level_gate_line_3_i, level_gate_line_2_i,
                      level_gate_line_1_i, level_gate_line_0_i,
                      target_clk_line_3_i, target_clk_line_2_i,
                      target_clk_line_1_i, target_clk_line_0_i};

  // two flops per line, third flop for edges
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      sync3 <= 8'h00;
    end else begin
      sync1 <= raw_lines;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  assign clk_lvl  = sync2[3:0];
  assign gate_lvl = sync2[7:4];
  assign clk_rise = sync2[3:0] & ~sync3[3:0];
  assign clk_fall = ~sync2[3:0] & sync3[3:0];

  // one qualifier term as a level
  function qual_term;
    input [4:0] q;
    input [3:0] c;
    input [3:0] g;
    reg         lvl;
    begin
      lvl = q[`ASC_Q_CLK] ? c[q[`ASC_Q_IDX]] : g[q[`ASC_Q_IDX]];
      qual_term = lvl ^ q[`ASC_Q_INV];
    end
  endfunction

  // one equation line: edge and combined qualifiers
  function line_eval;
    input [19:0] cfg;
    input [3:0]  c;
    input [3:0]  g;
    input [3:0]  rise;
    input [3:0]  fall;
    reg          edge_seen;
    reg          r;
    begin
      edge_seen = cfg[`ASC_LN_FALL] ? fall[cfg[`ASC_LN_SEL]]
                                    : rise[cfg[`ASC_LN_SEL]];
      r = 1'b1;
      if (cfg[3 + `ASC_Q_EN]) begin
        r = qual_term(cfg[`ASC_LN_Q0], c, g);
      end
      if (cfg[8 + `ASC_Q_EN]) begin
        if (cfg[`ASC_LN_OP1]) begin
          r = r | qual_term(cfg[`ASC_LN_Q1], c, g);
        end else begin
          r = r & qual_term(cfg[`ASC_LN_Q1], c, g);
        end
      end
      if (cfg[13 + `ASC_Q_EN]) begin
        if (cfg[`ASC_LN_OP2]) begin
          r = r | qual_term(cfg[`ASC_LN_Q2], c, g);
        end else begin
          r = r & qual_term(cfg[`ASC_LN_Q2], c, g);
        end
      end
      line_eval = edge_seen & r;
    end
  endfunction

  // qualifiers packed left, none shares the clock index
  function line_legal;
    input [19:0] cfg;
    reg   [1:0]  sel;
    begin
      sel = cfg[`ASC_LN_SEL];
      line_legal = 1'b1;
      if (cfg[3 + `ASC_Q_EN] && cfg[4:3] == sel) begin
        line_legal = 1'b0;
      end
      if (cfg[8 + `ASC_Q_EN] && cfg[9:8] == sel) begin
        line_legal = 1'b0;
      end
      if (cfg[13 + `ASC_Q_EN] && cfg[14:13] == sel) begin
        line_legal = 1'b0;
      end
      if (cfg[8 + `ASC_Q_EN] && !cfg[3 + `ASC_Q_EN]) begin
        line_legal = 1'b0;
      end
      if (cfg[13 + `ASC_Q_EN] && !cfg[8 + `ASC_Q_EN]) begin
        line_legal = 1'b0;
      end
    end
  endfunction

  // cycles for one ps period, never below one
  function [13:0] ps_cycles;
    input integer ps;
    integer       t;
    begin
      t = ps / `ASC_CLK_PS;
      if (t < 1) begin
        t = 1;
      end
      ps_cycles = t[13:0];
    end
  endfunction

  // time base period table
  always @* begin
    case (per_idx)
      5'h00:   tb_target = ps_cycles(`ASC_PER_2P5NS_PS);
      5'h01:   tb_target = ps_cycles(`ASC_PER_5NS_PS);
      5'h02:   tb_target = ps_cycles(`ASC_PER_10NS_PS);
      5'h03:   tb_target = ps_cycles(`ASC_PER_20NS_PS);
      5'h04:   tb_target = ps_cycles(`ASC_PER_50NS_PS);
      5'h05:   tb_target = ps_cycles(`ASC_PER_100NS_PS);
      5'h06:   tb_target = ps_cycles(`ASC_PER_200NS_PS);
      5'h07:   tb_target = ps_cycles(`ASC_PER_500NS_PS);
      5'h08:   tb_target = ps_cycles(`ASC_PER_1US_PS);
      5'h09:   tb_target = ps_cycles(`ASC_PER_2US_PS);
      5'h0A:   tb_target = ps_cycles(`ASC_PER_5US_PS);
      5'h0B:   tb_target = ps_cycles(`ASC_PER_10US_PS);
      5'h0C:   tb_target = ps_cycles(`ASC_PER_20US_PS);
      5'h0D:   tb_target = ps_cycles(`ASC_PER_50US_PS);
      5'h0E:   tb_target = ps_cycles(`ASC_PER_100US_PS);
      5'h0F:   tb_target = ps_cycles(`ASC_PER_200US_PS);
      5'h10:   tb_target = PER_500US_CYCLES;
      5'h11:   tb_target = PER_1MS_CYCLES;
      default: tb_target = PER_1MS_CYCLES;
    endcase
  end

  // internal time base
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tb_cnt  <= 14'h0000;
      tb_tick <= 1'b0;
    end else if (tb_cnt >= tb_target - 14'h0001) begin
      tb_cnt  <= 14'h0000;
      tb_tick <= 1'b1;
    end else begin
      tb_cnt  <= tb_cnt + 14'h0001;
      tb_tick <= 1'b0;
    end
  end

  // strobe selection per clock mode
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      line_hits[i] = (i < line_cnt) &&
                     line_eval(line_cfg[i], clk_lvl, gate_lvl, clk_rise, clk_fall);
    end
    case (clk_mode)
      `ASC_CLK_INT:    next_strobe = tb_tick;
      `ASC_CLK_EXT:    next_strobe = |line_hits;
      `ASC_CLK_CUSTOM: next_strobe = custom_strobe_i;
      default:         next_strobe = 1'b0;
    endcase
  end

  // bus decode and write merge
  assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_stb   = bus_req & wb_we_i;
  assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign hit_line = (wb_adr_i >= `ASC_OFF_LINE0) && (wb_adr_i <= `ASC_OFF_LINE3) &&
                    (wb_adr_i[1:0] == 2'h0);
  assign line_adr = wb_adr_i[3:2];
  assign ctrl_rd  = {19'h00000, per_idx, 2'h0, clk_mode, 2'h0, sup_mode};
  assign ctrl_new = (ctrl_rd & ~wmask) | (wb_dat_i & wmask);
  assign line_new = (line_cfg[line_adr] & ~wmask[19:0]) | (wb_dat_i[19:0] & wmask[19:0]);
  assign new_sup  = ctrl_new[`ASC_CTRL_SUP];
  assign new_clk  = ctrl_new[`ASC_CTRL_CLK];
  assign new_per  = (new_sup != sup_mode) ?
                    ((new_sup == `ASC_SUP_FAST) ? `ASC_PER_IDX_5NS : `ASC_PER_IDX_10NS) :
                    ctrl_new[`ASC_CTRL_PER];

  // control write legality
  always @* begin
    ctrl_ok = 1'b1;
    case (new_sup)
      `ASC_SUP_GP:     ctrl_ok = (new_clk != `ASC_CLK_CUSTOM) &&
                                 (new_clk != 2'h3) &&
                                 (new_per >= `ASC_PER_IDX_10NS);
      `ASC_SUP_FAST:   ctrl_ok = (new_clk == `ASC_CLK_INT);
      `ASC_SUP_CUSTOM: ctrl_ok = (new_clk != 2'h3) &&
                                 (new_per >= `ASC_PER_IDX_10NS);
      default:         ctrl_ok = 1'b0;
    endcase
    if (new_per > `ASC_PER_IDX_MAX) begin
      ctrl_ok = 1'b0;
    end
  end

  // register file and line list
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sup_mode    <= `ASC_SUP_GP;
      clk_mode    <= `ASC_CLK_INT;
      per_idx     <= `ASC_PER_IDX_10NS;
      line_cnt    <= `ASC_LINES_ONE;
      line_cfg[0] <= `ASC_LN_DEFAULT;
      line_cfg[1] <= `ASC_LN_DEFAULT;
      line_cfg[2] <= `ASC_LN_DEFAULT;
      line_cfg[3] <= `ASC_LN_DEFAULT;
      refused     <= 1'b0;
    end else begin
      if (wr_stb && wb_adr_i == `ASC_OFF_STATUS && wb_sel_i[3] &&
          wb_dat_i[`ASC_ST_REFUSED]) begin
        refused <= 1'b0;
      end
      if (wr_stb && wb_adr_i == `ASC_OFF_CTRL) begin
        if (ctrl_ok) begin
          sup_mode <= new_sup;
          clk_mode <= new_clk;
          per_idx  <= new_per;
        end else begin
          refused <= 1'b1;
        end
      end
      if (wr_stb && hit_line) begin
        if ({1'b0, line_adr} < line_cnt && line_legal(line_new)) begin
          line_cfg[line_adr] <= line_new;
        end else begin
          refused <= 1'b1;
        end
      end
      if (wr_stb && wb_adr_i == `ASC_OFF_LINE_CMD && wb_sel_i[0]) begin
        if (wb_dat_i[`ASC_CMD_ADD]) begin
          if (line_cnt < `ASC_LINES_MAX) begin
            line_cfg[line_cnt[1:0]] <= `ASC_LN_DEFAULT;
            line_cnt <= line_cnt + 3'h1;
          end else begin
            refused <= 1'b1;
          end
        end else if (wb_dat_i[`ASC_CMD_DEL]) begin
          if ({1'b0, wb_dat_i[`ASC_CMD_IDX]} >= line_cnt) begin
            refused <= 1'b1;
          end else if (line_cnt == `ASC_LINES_ONE) begin
            line_cfg[0] <= `ASC_LN_DEFAULT;
          end else begin
            for (j = 0; j < 3; j = j + 1) begin
              if (j >= wb_dat_i[`ASC_CMD_IDX]) begin
                line_cfg[j] <= line_cfg[j + 1];
              end
            end
            line_cnt <= line_cnt - 3'h1;
          end
        end else if (wb_dat_i[`ASC_CMD_DEF]) begin
          if (clk_mode == `ASC_CLK_EXT) begin
            line_cfg[0] <= `ASC_LN_DEFAULT;
            line_cnt    <= `ASC_LINES_ONE;
          end else begin
            refused <= 1'b1;
          end
        end
      end
    end
  end

  // sample strobe, count and width outputs
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_strobe_o <= 1'b0;
      smp_cnt         <= 32'h00000000;
      custom_sel_o    <= 1'b0;
      chan_width_o    <= `ASC_WIDTH_FULL;
      mem_depth_k_o   <= `ASC_DEPTH_FULL_K;
    end else begin
      sample_strobe_o <= next_strobe;
      if (next_strobe) begin
        smp_cnt <= smp_cnt + 32'h00000001;
      end
      custom_sel_o <= (clk_mode == `ASC_CLK_CUSTOM);
      if (sup_mode != `ASC_SUP_FAST) begin
        chan_width_o  <= `ASC_WIDTH_FULL;
        mem_depth_k_o <= `ASC_DEPTH_FULL_K;
      end else if (per_idx == `ASC_PER_IDX_2P5NS) begin
        chan_width_o  <= `ASC_WIDTH_QUARTER;
        mem_depth_k_o <= `ASC_DEPTH_QUART_K;
      end else begin
        chan_width_o  <= `ASC_WIDTH_HALF;
        mem_depth_k_o <= `ASC_DEPTH_HALF_K;
      end
    end
  end

  // read mux
  always @* begin
    rd_data = 32'h00000000;
    if (wb_adr_i == `ASC_OFF_CTRL) begin
      rd_data = ctrl_rd;
    end else if (wb_adr_i == `ASC_OFF_STATUS) begin
      rd_data[`ASC_ST_WIDTH]   = chan_width_o;
      rd_data[`ASC_ST_DEPTH]   = mem_depth_k_o;
      rd_data[`ASC_ST_LINES]   = line_cnt;
      rd_data[`ASC_ST_REFUSED] = refused;
    end else if (wb_adr_i == `ASC_OFF_SMP_CNT) begin
      rd_data = smp_cnt;
    end else if (hit_line) begin
      rd_data[19:0] = line_cfg[line_adr];
    end
  end

  // wishbone answer, one cycle after the request
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

endmodule // asc_sample_clock_select

`default_nettype wire

// ### test/asc_target_model.sv
// Purpose: target side driving the clock and gate lines
// Assumes: clock lines toggle every 400 ns only while a burst runs
// Notes:   lines hold their last level between bursts
`timescale 1ns/1ps
`default_nettype none
module asc_target_model (
  input  wire logic       go_i,
  input  wire logic [3:0] mask_i,
  input  wire logic [3:0] toggles_i,
  input  wire logic [3:0] gate_lvl_i,
  output logic      [3:0] clk_lines_o,
  output logic      [3:0] gate_lines_o,
  output logic            busy_o
);
  assign gate_lines_o = gate_lvl_i;
  initial begin
    clk_lines_o = 4'h0;
    busy_o = 1'b0;
  end
  always begin
    wait (go_i === 1'b1);
    busy_o = 1'b1;
    #537;
    repeat (toggles_i) begin
      clk_lines_o = clk_lines_o ^ mask_i;
      #400;
    end
    busy_o = 1'b0;
    wait (go_i === 1'b0);
  end
endmodule // asc_target_model
`default_nettype wire

// ### test/asc_scs_chk.sv
// Purpose: bus and output checks for the sample clock select block
// Assumes: one core clock domain, async active-low reset
// Notes:   bound to the design top, sees its ports only
`timescale 1ns/1ps
`default_nettype none
`include "asc_map.vh"
module asc_scs_chk (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sample_strobe_o,
  input wire logic        custom_sel_o,
  input wire logic [6:0]  chan_width_o,
  input wire logic [5:0]  mem_depth_k_o
);
  logic take;
  logic wr_ack;
  assign take   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ack = wb_ack_o && wb_we_i;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_answer;
    take |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("no ack one cycle after request");
  property p_ack_cause;
    wb_ack_o |-> $past(take);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without a request");
  property p_width_depth;
    (chan_width_o == `ASC_WIDTH_FULL && mem_depth_k_o == `ASC_DEPTH_FULL_K) ||
    (chan_width_o == `ASC_WIDTH_HALF && mem_depth_k_o == `ASC_DEPTH_HALF_K) ||
    (chan_width_o == `ASC_WIDTH_QUARTER && mem_depth_k_o == `ASC_DEPTH_QUART_K);
  endproperty
  a_width_depth: assert property (p_width_depth) else $error("width and depth mismatch");
  property p_rd_hold;
    !(take && !wb_we_i) |=> $stable(wb_dat_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  property p_unmapped_zero;
    wb_ack_o && !wb_we_i && wb_adr_i >= 8'h20 |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_status_mirror;
    wb_ack_o && !wb_we_i && wb_adr_i == `ASC_OFF_STATUS |->
      wb_dat_o[`ASC_ST_WIDTH] == chan_width_o && wb_dat_o[`ASC_ST_DEPTH] == mem_depth_k_o;
  endproperty
  a_status_mirror: assert property (p_status_mirror) else $error("status differs");
  property p_reset_vals;
    $rose(rst_n_i) |-> chan_width_o == `ASC_WIDTH_FULL && !custom_sel_o && !wb_ack_o;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad value after reset");
  property p_mode_on_write;
    $changed(custom_sel_o) || $changed(chan_width_o) |->
      wr_ack || $past(wr_ack) || $past(wr_ack, 2);
  endproperty
  a_mode_on_write: assert property (p_mode_on_write) else $error("mode moved alone");
  c_strobe: cover property (sample_strobe_o && !custom_sel_o);
  c_custom: cover property (sample_strobe_o && custom_sel_o);
  c_quarter: cover property (chan_width_o == `ASC_WIDTH_QUARTER);
endmodule // asc_scs_chk
bind asc_sample_clock_select asc_scs_chk u_chk (
  .core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .sample_strobe_o(sample_strobe_o),
  .custom_sel_o(custom_sel_o),
  .chan_width_o(chan_width_o),
  .mem_depth_k_o(mem_depth_k_o)
);
`default_nettype wire

// ### test/tb.sv
// Purpose: self-checking bench for the sample clock select block
// Assumes: 10 MHz core clock, classic Wishbone master tasks
// Notes:   long periods shortened through the design parameters
`timescale 1ns/1ps
`default_nettype none
`include "asc_map.vh"
module tb;
  logic        core_clk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        custom_strobe_i, sample_strobe_o, custom_sel_o, go, busy;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, mask, tog, gate_lvl, clk_ln, gate_ln;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [6:0]  chan_width_o;
  logic [5:0]  mem_depth_k_o;
  int          err_total, samples_checked, strobe_cnt;
  localparam logic [35:0] EXT_TAB [15] = '{36'h00003_8101, 36'h00003_8100,
    36'h00007_8100, 36'h00007_8101, 36'h00083_8200, 36'h00083_8211, 36'h000C3_8201,
    36'h000AB_2100, 36'h000AB_8201, 36'h000AB_2100, 36'h000AB_8200, 36'h25183_8230,
    36'hA5183_8241, 36'hA5183_8210, 36'hE5183_8211};
  asc_sample_clock_select #(.PER_500US_CYCLES(14'd50), .PER_1MS_CYCLES(14'd100)) dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .target_clk_line_0_i(clk_ln[0]),
    .target_clk_line_1_i(clk_ln[1]), .target_clk_line_2_i(clk_ln[2]),
    .target_clk_line_3_i(clk_ln[3]), .level_gate_line_0_i(gate_ln[0]),
    .level_gate_line_1_i(gate_ln[1]), .level_gate_line_2_i(gate_ln[2]),
    .level_gate_line_3_i(gate_ln[3]), .custom_strobe_i(custom_strobe_i),
    .sample_strobe_o(sample_strobe_o), .custom_sel_o(custom_sel_o),
    .chan_width_o(chan_width_o), .mem_depth_k_o(mem_depth_k_o));
  asc_target_model u_target (.go_i(go), .mask_i(mask), .toggles_i(tog), .gate_lvl_i(gate_lvl),
    .clk_lines_o(clk_ln), .gate_lines_o(gate_ln), .busy_o(busy));
  initial begin
    {core_clk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, custom_strobe_i, go} = 7'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i, mask, tog, gate_lvl} = 56'h0;
    {err_total, samples_checked, strobe_cnt} = 96'h0;
  end
  always #50 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (sample_strobe_o === 1'b1) strobe_cnt <= strobe_cnt + 1;
  task automatic print_verdict;
    if (err_total == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    @(posedge core_clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) chk("wb_ack_o", 32'h1, 32'h0);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk(nm, e, q);
  endtask
  task automatic ref_chk(input string nm, input logic e);
    xfer(1'b0, `ASC_OFF_STATUS, 32'h0, 4'hF);
    chk(nm, {31'h0, e}, {31'h0, q[`ASC_ST_REFUSED]});
    xfer(1'b1, `ASC_OFF_STATUS, 32'h0100_0000, 4'h8);
  endtask
  task automatic burst(input logic [3:0] m, input logic [3:0] t, output int n);
    int c0, k;
    c0 = strobe_cnt;
    @(posedge core_clk_i);
    {mask, tog, go} <= {m, t, 1'b1};
    @(posedge core_clk_i);
    for (k = 0; k < 200 && busy === 1'b1; k++) @(posedge core_clk_i);
    go <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    n = strobe_cnt - c0;
  endtask
  task automatic gap(output int g);
    g = 0;
    do begin
      @(posedge core_clk_i);
      g++;
    end while (sample_strobe_o !== 1'b1 && g < 5000);
  endtask
  task automatic t_defaults;
    rd_chk("ctrl", `ASC_OFF_CTRL, 32'h0000_0200);
    rd_chk("status", `ASC_OFF_STATUS, 32'h0001_0860);
    rd_chk("line0", `ASC_OFF_LINE0, {12'h0, `ASC_LN_DEFAULT});
    rd_chk("unmapped", 8'h40, 32'h0);
  endtask
  task automatic t_ext;
    int n;
    wr(`ASC_OFF_CTRL, 32'h0210);
    foreach (EXT_TAB[i]) begin
      wr(`ASC_OFF_LINE0, {12'h0, EXT_TAB[i][35:16]});
      gate_lvl <= EXT_TAB[i][7:4];
      burst(EXT_TAB[i][15:12], EXT_TAB[i][11:8], n);
      chk("ext strobes", {28'h0, EXT_TAB[i][3:0]}, n);
    end
  endtask
  task automatic t_lines;
    int n;
    wr(`ASC_OFF_LINE0, 32'h3);
    repeat (4) wr(`ASC_OFF_LINE_CMD, 32'h10);
    ref_chk("fifth add", 1'b1);
    xfer(1'b0, `ASC_OFF_STATUS, 32'h0, 4'hF);
    chk("lines", 32'h4, {29'h0, q[`ASC_ST_LINES]});
    wr(8'h14, 32'h2);
    burst(4'h4, 4'h2, n);
    chk("clk2 line", 32'h1, n);
    burst(4'h8, 4'h2, n);
    chk("or of lines", 32'h1, n);
    wr(8'h14, 32'h92);
    ref_chk("gate n on clock n", 1'b1);
    wr(8'h14, 32'hB2);
    ref_chk("clock n as qual", 1'b1);
    rd_chk("line1 kept", 8'h14, 32'h2);
    wr(8'h14, 32'h1102);
    ref_chk("gap in quals", 1'b1);
    wr(8'h14, 32'h82);
    ref_chk("legal qual", 1'b0);
    for (int i = 3; i > 0; i--) wr(`ASC_OFF_LINE_CMD, 32'h20 | i);
    wr(8'h14, 32'h2);
    ref_chk("line past count", 1'b1);
    wr(`ASC_OFF_LINE0, 32'h7);
    wr(`ASC_OFF_LINE_CMD, 32'h20);
    rd_chk("last delete", `ASC_OFF_LINE0, 32'h3);
    wr(`ASC_OFF_LINE0, 32'h7);
    wr(`ASC_OFF_LINE_CMD, 32'h40);
    rd_chk("restore", `ASC_OFF_LINE0, 32'h3);
  endtask
  task automatic t_support;
    wr(`ASC_OFF_CTRL, 32'h0101);
    rd_chk("fast ctrl", `ASC_OFF_CTRL, 32'h0101);
    chk("half width", 32'h30, {25'h0, chan_width_o});
    chk("half depth", 32'h10, {26'h0, mem_depth_k_o});
    wr(`ASC_OFF_CTRL, 32'h0001);
    rd_chk("fast 2p5", `ASC_OFF_CTRL, 32'h0001);
    chk("quarter width", 32'h18, {25'h0, chan_width_o});
    chk("quarter depth", 32'h20, {26'h0, mem_depth_k_o});
    wr(`ASC_OFF_CTRL, 32'h0011);
    ref_chk("fast ext", 1'b1);
    wr(`ASC_OFF_CTRL, 32'h1100);
    rd_chk("gp default", `ASC_OFF_CTRL, 32'h0200);
    wr(`ASC_OFF_CTRL, 32'h0100);
    ref_chk("gp 5ns", 1'b1);
    wr(`ASC_OFF_CTRL, 32'h1200);
    ref_chk("past 1ms", 1'b1);
    wr(`ASC_OFF_CTRL, 32'h0220);
    ref_chk("gp custom", 1'b1);
  endtask
  task automatic t_internal;
    int ps, e, g;
    ps = 10000;
    for (int i = 2; i < 18; i++) begin
      wr(`ASC_OFF_CTRL, i << 8);
      e = (ps < 100000) ? 1 : ps / 100000;
      if (i == 16) e = 50;
      if (i == 17) e = 100;
      repeat (3) gap(g);
      chk("tick gap", e, g);
      ps = (i % 3 == 0) ? ps * 5 / 2 : ps * 2;
    end
  endtask
  task automatic t_custom;
    logic [31:0] c0;
    wr(`ASC_OFF_CTRL, 32'h0202);
    wr(`ASC_OFF_CTRL, 32'h0212);
    ref_chk("custom ext", 1'b0);
    wr(`ASC_OFF_CTRL, 32'h0222);
    xfer(1'b0, `ASC_OFF_SMP_CNT, 32'h0, 4'hF);
    c0 = q;
    chk("custom_sel_o", 32'h1, {31'h0, custom_sel_o});
    repeat (5) begin
      @(posedge core_clk_i) custom_strobe_i <= 1'b1;
      @(posedge core_clk_i) custom_strobe_i <= 1'b0;
      @(posedge core_clk_i);
    end
    rd_chk("sample count", `ASC_OFF_SMP_CNT, c0 + 32'd5);
  endtask
  initial begin
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    t_defaults();
    t_ext();
    t_lines();
    t_support();
    t_internal();
    t_custom();
    print_verdict();
  end
  initial begin
    #5000000;
    err_total++;
    print_verdict();
  end
endmodule // tb
`default_nettype wire
